// file: verilog/acc_comp.v
// Analog command compensation, filtering and AHB-Lite register slave
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "acc_consts.vh"
module acc_comp #(
	parameter W           = 12,
	parameter TICK_CYCLES = `ACC_TICK_CYCLES
) (
	sys_clk,
	nrst,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hready,
	hwdata,
	hrdata,
	hreadyout,
	hresp,
	voltMainIn,
	currMainIn,
	auxIn,
	multiSpeedIn,
	multiSpeedActive,
	torqueIn,
	forward_start,
	second_function_select,
	current_input_enable,
	freqCmd,
	reverseRun,
	torqueCmd
);
	input  wire                 sys_clk;
	input  wire                 nrst;
	input  wire                 hsel;
	input  wire [31:0]          haddr;
	input  wire [1:0]           htrans;
	input  wire                 hwrite;
	input  wire [2:0]           hsize;
	input  wire                 hready;
	input  wire [31:0]          hwdata;
	output reg  [31:0]          hrdata;
	output wire                 hreadyout;
	output wire                 hresp;
	input  wire [W-1:0]         voltMainIn;
	input  wire [W-1:0]         currMainIn;
	input  wire signed [W-1:0]  auxIn;
	input  wire [W-1:0]         multiSpeedIn;
	input  wire                 multiSpeedActive;
	input  wire signed [W-1:0]  torqueIn;
	input  wire                 forward_start;
	input  wire                 second_function_select;
	input  wire                 current_input_enable;
	output reg  [W-1:0]         freqCmd;
	output reg                  reverseRun;
	output wire signed [W-1:0]  torqueCmd;

	localparam signed [31:0] FS  = (32'sd1 <<< W) - 32'sd1;
	localparam signed [31:0] PCT = `ACC_PCT_FULL;

	// Software settings
	reg [4:0]  analog_input_select_q;
	reg        multispeed_comp_select_q;
	reg [3:0]  input_filter_code_q;
	reg [6:0]  aux_ratio_voltage_main_q;
	reg [6:0]  aux_ratio_current_main_q;
	reg [7:0]  override_bias_q;
	reg [7:0]  override_gain_q;
	reg [15:0] speed_filter_primary_q;
	reg [15:0] speed_filter_alternate_q;
	reg [15:0] torque_filter_primary_q;
	reg [15:0] torque_filter_alternate_q;
	reg [7:0]  analog_offset_adjust_q;

	// Bus data phase state
	reg        wrPend_q;
	reg [7:0]  wrAddr_q;
	wire       addrPhase;

	// Sample tick
	reg [31:0] tickCnt_q;
	reg        tick_q;

	// Filter time constants in ms, translated to shift counts
	function [15:0] codeToMs;
		input [3:0] code;
		begin
			case (code)
				4'h0:    codeToMs = 16'h000A;
				4'h1:    codeToMs = 16'h0014;
				4'h2:    codeToMs = 16'h0028;
				4'h3:    codeToMs = 16'h0050;
				4'h4:    codeToMs = 16'h00A0;
				4'h5:    codeToMs = 16'h0140;
				4'h6:    codeToMs = 16'h01F4;
				4'h7:    codeToMs = 16'h0320;
				default: codeToMs = 16'h03E8;
			endcase
		end
	endfunction

	// Tick of 1 ms: alpha = 1/2^k with 2^k nearest at or below tau in ms, k held to 1..13 except tau 0, which gives k 0
	function [3:0] msToShift;
		input [15:0] ms;
		integer i;
		begin
			msToShift = 4'h0;
			for (i = 1; i < 14; i = i + 1) begin
				if (ms >= (16'h0001 << i))
					msToShift = i[3:0];
			end
			if (ms != 16'h0000 && msToShift == 4'h0)
				msToShift = 4'h1;
		end
	endfunction

	wire [3:0]  inShift;
	wire [15:0] spdTau;
	wire [15:0] trqTau;
	wire [3:0]  spdShift;
	wire [3:0]  trqShift;

	assign inShift = msToShift(codeToMs(input_filter_code_q));
	// Second motor selects the alternate constants
	assign spdTau = second_function_select ? speed_filter_alternate_q
		: speed_filter_primary_q;
	assign trqTau = second_function_select ? torque_filter_alternate_q
		: torque_filter_primary_q;
	assign spdShift = (spdTau == `ACC_TAU_DEFER) ? inShift
		: msToShift(spdTau);
	assign trqShift = (trqTau == `ACC_TAU_DEFER) ? inShift
		: msToShift(trqTau);

	// Divider giving a one-cycle tick for all filters
	always @(posedge sys_clk) begin
		if (!nrst) begin
			tickCnt_q <= 32'h00000000;
			tick_q    <= 1'b0;
		end else if (tickCnt_q >= TICK_CYCLES - 1) begin
			tickCnt_q <= 32'h00000000;
			tick_q    <= 1'b1;
		end else begin
			tickCnt_q <= tickCnt_q + 32'h00000001;
			tick_q    <= 1'b0;
		end
	end

	// Input filters on the three analog channels, one shared constant
	wire signed [W:0] rawIn [0:2];
	wire signed [W:0] fltIn [0:2];
	assign rawIn[0] = {1'b0, voltMainIn};
	assign rawIn[1] = {1'b0, currMainIn};
	assign rawIn[2] = {auxIn[W-1], auxIn};
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gInFlt
			acc_lpf #(.W(W+1)) uFlt (
				.sys_clk (sys_clk),
				.nrst    (nrst),
				.tick    (tick_q),
				.shift   (inShift),
				.x       (rawIn[g]),
				.y       (fltIn[g])
			);
		end
	endgenerate

	// Mode decode from the selection code
	wire polRev;
	wire ovrMode;
	assign polRev = (analog_input_select_q >= `ACC_SEL_POL_MIN) &&
		(analog_input_select_q <= `ACC_SEL_POL_MAX);
	assign ovrMode = (analog_input_select_q == 5'h04) ||
		(analog_input_select_q == 5'h05) ||
		(analog_input_select_q == 5'h0E) ||
		(analog_input_select_q == 5'h0F);

	// Command datapath, all in 32-bit signed arithmetic
	reg signed [31:0] volt;
	reg signed [31:0] curr;
	reg signed [31:0] aux;
	reg signed [31:0] offV;
	reg signed [31:0] base;
	reg signed [31:0] ratio;
	reg signed [31:0] auxAdd;
	reg signed [31:0] sum;
	reg signed [31:0] ovMain;
	reg signed [31:0] comp;
	reg signed [31:0] cmd;
	reg               rev;
	always @* begin
		volt = {{(31-W){1'b0}}, fltIn[0]};
		curr = {{(31-W){1'b0}}, fltIn[1]};
		aux  = {{(31-W){fltIn[2][W]}}, fltIn[2]};
		// Offset: positive setting raises the zero-speed threshold
		offV = (FS * ($signed({24'h0, analog_offset_adjust_q}) - PCT))
			/ PCT;
		volt = volt - offV;
		if (volt < 0)
			volt = 0;
		if (volt > FS)
			volt = FS;
		// Added compensation path
		ratio = current_input_enable
			? $signed({25'h0, aux_ratio_current_main_q})
			: $signed({25'h0, aux_ratio_voltage_main_q});
		if (multiSpeedActive)
			base = $signed({{(32-W){1'b0}}, multiSpeedIn});
		else if (current_input_enable)
			base = curr;
		else
			base = volt;
		if (multiSpeedActive && !multispeed_comp_select_q)
			auxAdd = 0;
		else
			auxAdd = (aux * ratio) / PCT;
		sum = base + auxAdd;
		// Override path; main speed magnitude from aux, current or multi
		if (multiSpeedActive)
			ovMain = $signed({{(32-W){1'b0}}, multiSpeedIn});
		else if (current_input_enable)
			ovMain = curr;
		else
			ovMain = (aux < 0) ? -aux : aux;
		comp = $signed({24'h0, override_bias_q}) +
			(($signed({24'h0, override_gain_q}) -
			$signed({24'h0, override_bias_q})) * volt) / FS;
		cmd = 0;
		rev = 1'b0;
		if (ovrMode) begin
			if (ovMain == 0 ||
			    (multiSpeedActive && !multispeed_comp_select_q))
				cmd = ovMain;
			else
				cmd = (ovMain * comp) / PCT;
			// Signed aux as main speed runs by its sign
			rev = polRev && forward_start && !multiSpeedActive &&
				!current_input_enable && aux < 0;
		end else if (sum < 0) begin
			if (polRev && forward_start) begin
				cmd = -sum;
				rev = 1'b1;
			end else begin
				cmd = 0;
			end
		end else begin
			cmd = sum;
		end
		if (cmd > FS)
			cmd = FS;
	end

	// Speed and torque command filters
	wire signed [W:0] spdFlt;
	acc_lpf #(.W(W+1)) uSpd (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.tick    (tick_q),
		.shift   (spdShift),
		.x       (cmd[W:0]),
		.y       (spdFlt)
	);
	acc_lpf #(.W(W)) uTrq (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.tick    (tick_q),
		.shift   (trqShift),
		.x       (torqueIn),
		.y       (torqueCmd)
	);

	// Output registers
	always @(posedge sys_clk) begin
		if (!nrst) begin
			freqCmd    <= {W{1'b0}};
			reverseRun <= 1'b0;
		end else begin
			freqCmd    <= spdFlt[W] ? {W{1'b0}} : spdFlt[W-1:0];
			reverseRun <= rev;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addrPhase = hsel && htrans[1] && hready;

	// Address phase latch; read data registered for the data phase
	always @(posedge sys_clk) begin
		if (!nrst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata   <= 32'h00000000;
		end else begin
			wrPend_q <= addrPhase && hwrite;
			wrAddr_q <= haddr[7:0];
			hrdata   <= 32'h00000000;
			if (addrPhase && !hwrite) begin
				case (haddr[7:0])
					`ACC_REG_CTRL: begin
						hrdata[`ACC_CTRL_SEL_LSB+:5] <=
							analog_input_select_q;
						hrdata[`ACC_CTRL_MSC_BIT] <=
							multispeed_comp_select_q;
						hrdata[`ACC_CTRL_FLT_LSB+:4] <=
							input_filter_code_q;
					end
					`ACC_REG_RATIO: begin
						hrdata[`ACC_RATIO_V_LSB+:7] <=
							aux_ratio_voltage_main_q;
						hrdata[`ACC_RATIO_C_LSB+:7] <=
							aux_ratio_current_main_q;
					end
					`ACC_REG_OVR: begin
						hrdata[`ACC_OVR_BIAS_LSB+:8] <= override_bias_q;
						hrdata[`ACC_OVR_GAIN_LSB+:8] <= override_gain_q;
					end
					`ACC_REG_SPDF: begin
						hrdata[`ACC_TAU_PRI_LSB+:16] <=
							speed_filter_primary_q;
						hrdata[`ACC_TAU_ALT_LSB+:16] <=
							speed_filter_alternate_q;
					end
					`ACC_REG_TRQF: begin
						hrdata[`ACC_TAU_PRI_LSB+:16] <=
							torque_filter_primary_q;
						hrdata[`ACC_TAU_ALT_LSB+:16] <=
							torque_filter_alternate_q;
					end
					`ACC_REG_OFFS:
						hrdata[7:0] <= analog_offset_adjust_q;
					`ACC_REG_STAT: begin
						hrdata[W-1:0] <= freqCmd;
						hrdata[`ACC_STAT_REV_BIT] <= reverseRun;
						hrdata[`ACC_STAT_OVR_BIT] <= ovrMode;
						hrdata[`ACC_STAT_POL_BIT] <= polRev;
					end
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Register writes in the data phase; unmapped writes are dropped
	always @(posedge sys_clk) begin
		if (!nrst) begin
			analog_input_select_q     <= `ACC_RST_SEL;
			multispeed_comp_select_q  <= `ACC_RST_MSC;
			input_filter_code_q       <= `ACC_RST_FLT;
			aux_ratio_voltage_main_q  <= `ACC_RST_RATIO_V;
			aux_ratio_current_main_q  <= `ACC_RST_RATIO_C;
			override_bias_q           <= `ACC_RST_BIAS;
			override_gain_q           <= `ACC_RST_GAIN;
			speed_filter_primary_q    <= `ACC_RST_TAU;
			speed_filter_alternate_q  <= `ACC_RST_TAU;
			torque_filter_primary_q   <= `ACC_RST_TAU;
			torque_filter_alternate_q <= `ACC_RST_TAU;
			analog_offset_adjust_q    <= `ACC_RST_OFFS;
		end else if (wrPend_q) begin
			case (wrAddr_q)
				`ACC_REG_CTRL: begin
					analog_input_select_q <=
						hwdata[`ACC_CTRL_SEL_LSB+:5];
					multispeed_comp_select_q <=
						hwdata[`ACC_CTRL_MSC_BIT];
					input_filter_code_q <= hwdata[`ACC_CTRL_FLT_LSB+:4];
				end
				`ACC_REG_RATIO: begin
					aux_ratio_voltage_main_q <=
						hwdata[`ACC_RATIO_V_LSB+:7];
					aux_ratio_current_main_q <=
						hwdata[`ACC_RATIO_C_LSB+:7];
				end
				`ACC_REG_OVR: begin
					override_bias_q <= hwdata[`ACC_OVR_BIAS_LSB+:8];
					override_gain_q <= hwdata[`ACC_OVR_GAIN_LSB+:8];
				end
				`ACC_REG_SPDF: begin
					speed_filter_primary_q <=
						hwdata[`ACC_TAU_PRI_LSB+:16];
					speed_filter_alternate_q <=
						hwdata[`ACC_TAU_ALT_LSB+:16];
				end
				`ACC_REG_TRQF: begin
					torque_filter_primary_q <=
						hwdata[`ACC_TAU_PRI_LSB+:16];
					torque_filter_alternate_q <=
						hwdata[`ACC_TAU_ALT_LSB+:16];
				end
				`ACC_REG_OFFS:
					analog_offset_adjust_q <= hwdata[7:0];
				default: ;
			endcase
		end
	end
endmodule // acc_comp

// file: verilog/acc_consts.vh
// Constants of the analog command compensation block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// Register byte offsets
`define ACC_REG_CTRL      8'h00
`define ACC_REG_RATIO     8'h04
`define ACC_REG_OVR       8'h08
`define ACC_REG_SPDF      8'h0C
`define ACC_REG_TRQF      8'h10
`define ACC_REG_OFFS      8'h14
`define ACC_REG_STAT      8'h18

// Field positions
`define ACC_CTRL_SEL_LSB  0
`define ACC_CTRL_MSC_BIT  8
`define ACC_CTRL_FLT_LSB  16
`define ACC_RATIO_V_LSB   0
`define ACC_RATIO_C_LSB   8
`define ACC_OVR_BIAS_LSB  0
`define ACC_OVR_GAIN_LSB  16
`define ACC_TAU_PRI_LSB   0
`define ACC_TAU_ALT_LSB   16
`define ACC_STAT_REV_BIT  16
`define ACC_STAT_OVR_BIT  17
`define ACC_STAT_POL_BIT  18

// Reset values
`define ACC_RST_SEL       5'h01
`define ACC_RST_MSC       1'h0
`define ACC_RST_FLT       4'h1
`define ACC_RST_RATIO_V   7'h64
`define ACC_RST_RATIO_C   7'h4B
`define ACC_RST_BIAS      8'h32
`define ACC_RST_GAIN      8'h96
`define ACC_RST_TAU       16'h270F
`define ACC_RST_OFFS      8'h64

// Codes and scales
`define ACC_TAU_DEFER     16'h270F
`define ACC_PCT_FULL      100
`define ACC_SEL_POL_MIN   5'h0A
`define ACC_SEL_POL_MAX   5'h11

// Timing: filter sample tick of 1 ms at a 25 ns clock
`define ACC_TICK_NS       1000000
`define ACC_CLK_NS        25
`define ACC_TICK_CYCLES   (`ACC_TICK_NS / `ACC_CLK_NS)

`endif

// file: verilog/acc_lpf.v
// First-order delay filter stage updated on a sample tick
`timescale 1ns/1ps
module acc_lpf #(
	parameter W = 16,
	parameter F = 8
) (
	sys_clk,
	nrst,
	tick,
	shift,
	x,
	y
);
	input  wire                 sys_clk;
	input  wire                 nrst;
	input  wire                 tick;
	input  wire [3:0]           shift;
	input  wire signed [W-1:0]  x;
	output wire signed [W-1:0]  y;

	reg  signed [W+F-1:0] acc_q;
	wire signed [W+F-1:0] xExt;
	wire signed [W+F-1:0] diff;

	assign xExt = {x, {F{1'b0}}};
	assign diff = xExt - acc_q;
	assign y    = acc_q[W+F-1:F];

	// Shift zero means no filtering; otherwise y += (x - y) / 2^shift
	always @(posedge sys_clk) begin
		if (!nrst) begin
			acc_q <= {(W+F){1'b0}};
		end else if (shift == 4'h0) begin
			acc_q <= xExt;
		end else if (tick) begin
			acc_q <= acc_q + (diff >>> shift);
		end
	end
endmodule // acc_lpf

// file: tb/acc_comp_props.sv
// Port checker for the analog command compensation block
`timescale 1ns/1ps
module acc_comp_props #(
	parameter W = 12
) (
	input wire                 sys_clk,
	input wire                 nrst,
	input wire                 hsel,
	input wire [31:0]          haddr,
	input wire [1:0]           htrans,
	input wire                 hwrite,
	input wire                 hready,
	input wire [31:0]          hwdata,
	input wire [31:0]          hrdata,
	input wire                 hreadyout,
	input wire                 hresp,
	input wire                 forward_start,
	input wire [W-1:0]         freqCmd,
	input wire                 reverseRun,
	input wire signed [W-1:0]  torqueCmd
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Bus phase decode
	wire take = hsel && htrans[1] && hready;
	wire rd   = take && !hwrite;
	logic [4:0] sel_q;
	logic       ctlWr_q;
	// Shadow of the select code; a write lands at the end of its data phase
	always @(posedge sys_clk) begin
		if (!nrst) begin
			sel_q   <= 5'h01;
			ctlWr_q <= 1'b0;
		end else begin
			ctlWr_q <= take && hwrite && haddr[7:0] == 8'h00;
			if (ctlWr_q)
				sel_q <= hwdata[4:0];
		end
	end
	wire ovrExp = sel_q == 5'h04 || sel_q == 5'h05 || sel_q == 5'h0E
		|| sel_q == 5'h0F;
	wire polExp = sel_q >= 5'h0A && sel_q <= 5'h11;
	sequence wrOffs; take && hwrite && haddr[7:0] == 8'h14; endsequence
	sequence rdOffs; rd && haddr[7:0] == 8'h14; endsequence
	sequence rdStat; rd && haddr[7:0] == 8'h18; endsequence
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	reset_clear_a: assert property (disable iff (1'b0) !nrst |=>
		hrdata == 32'h0 && freqCmd == '0 && !reverseRun && torqueCmd == '0)
		else $error("outputs not cleared by reset");
	rdata_idle_a: assert property (!rd |=> hrdata == 32'h0)
		else $error("read data outside a read");
	stat_freq_a: assert property (rdStat |=>
		hrdata[W-1:0] == $past(freqCmd) && hrdata[16] == $past(reverseRun))
		else $error("status does not mirror outputs");
	// Flags are sampled at the address phase, before a write landing there
	mode_flags_a: assert property (rdStat |=>
		hrdata[17] == $past(ovrExp) && hrdata[18] == $past(polExp))
		else $error("mode flags disagree with select code");
	offs_back_a: assert property (wrOffs ##2 rdOffs |=>
		hrdata[7:0] == $past(hwdata[7:0], 2))
		else $error("offset readback wrong");
	unmapped_zero_a: assert property (rd && haddr[7:0] == 8'h1C |=>
		hrdata == 32'h0)
		else $error("unmapped read not zero");
	rev_fwd_a: assert property ($rose(reverseRun) |->
		$past(forward_start))
		else $error("reverse without forward start");
	rev_code_a: assert property (reverseRun |->
		$past(polExp) || $past(polExp, 2))
		else $error("reverse outside polarity codes");
endmodule // acc_comp_props

bind acc_comp acc_comp_props #(.W(W)) u_props (.sys_clk, .nrst, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout,
	.hresp, .forward_start, .freqCmd, .reverseRun, .torqueCmd);

// file: tb/tb_top.sv
// Self-checking bench for the analog command compensation block
`timescale 1ns/1ps
module tb_top;
	localparam W  = 12;
	localparam TK = 4;
	logic               sys_clk = 1'b0;
	logic               nrst = 1'b0;
	logic               hsel = 1'b0;
	logic [31:0]        haddr = 32'h0;
	logic [1:0]         htrans = 2'h0;
	logic               hwrite = 1'b0;
	logic [31:0]        hwdata = 32'h0;
	logic [W-1:0]       voltMainIn = 12'h000;
	logic [W-1:0]       currMainIn = 12'h000;
	logic signed [W-1:0] auxIn = 12'sh000;
	logic [W-1:0]       multiSpeedIn = 12'h000;
	logic               multiSpeedActive = 1'b0;
	logic signed [W-1:0] torqueIn = 12'sh000;
	logic               forward_start = 1'b0;
	logic               second_function_select = 1'b0;
	logic               current_input_enable = 1'b0;
	wire [31:0]         hrdata;
	wire                hreadyout;
	wire                hresp;
	wire [W-1:0]        freqCmd;
	wire                reverseRun;
	wire signed [W-1:0] torqueCmd;
	logic [31:0]        rdv;
	int                 error_cnt = 0;
	int                 checks_done = 0;

	acc_comp #(.W(W), .TICK_CYCLES(TK)) u_dut (.sys_clk, .nrst, .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .voltMainIn, .currMainIn,
		.auxIn, .multiSpeedIn, .multiSpeedActive, .torqueIn,
		.forward_start, .second_function_select, .current_input_enable,
		.freqCmd, .reverseRun, .torqueCmd);

	// Clock at 40 MHz
	always #12.5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	// Filtered outputs settle within a few codes of the ideal value
	task automatic near(input string nm, input logic [W-1:0] e,
		input logic [W-1:0] g, input logic [W-1:0] t);
		logic [W-1:0] d;
		d = (g > e) ? g - e : e - g;
		checks_done++;
		if ((^g === 1'bx) || d > t) begin
			error_cnt++;
			$display("[FAIL] %s exp %0d got %0d", nm, e, g);
		end
	endtask

	// One single AHB transfer; read data taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic wt(input int n);
		repeat (n * TK) @(posedge sys_clk);
	endtask

	task automatic t_reset;
		logic [31:0] rv [8];
		rv = '{32'h0001_0001, 32'h0000_4B64, 32'h0096_0032, 32'h270F_270F,
			32'h270F_270F, 32'h0000_0064, 32'h0, 32'h0};
		wr(8'h18, 32'hFFFF_FFFF);
		wr(8'h1C, 32'hFFFF_FFFF);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0);
			chk("regReset", rv[i], rdv);
		end
		wr(8'h00, 32'h1);
		wr(8'h0C, 32'h0);
		wr(8'h10, 32'h0);
	endtask

	task automatic t_modes;
		for (int s = 0; s < 18; s++) begin
			wr(8'h00, 32'(s));
			wt(1);
			bus(1'b0, 8'h18, 32'h0);
			chk("ovrFlag", {31'h0, s inside {4, 5, 14, 15}}, rdv[17]);
			chk("polFlag", {31'h0, s >= 10}, rdv[18]);
		end
		wr(8'h00, 32'h1);
	endtask

	task automatic t_added;
		voltMainIn <= 12'd2000;
		auxIn <= 12'sd400;
		wt(100);
		near("addV", 12'd2400, freqCmd, 12'd24);
		wr(8'h04, 32'h4B32);
		wt(100);
		near("ratioV", 12'd2200, freqCmd, 12'd24);
		current_input_enable <= 1'b1;
		currMainIn <= 12'd1000;
		wt(100);
		near("ratioC", 12'd1300, freqCmd, 12'd24);
		current_input_enable <= 1'b0;
		wr(8'h04, 32'h4B64);
		voltMainIn <= 12'd100;
		auxIn <= -12'sd1000;
		wt(100);
		near("clamp", 12'd0, freqCmd, 12'd24);
		chk("fwdOnly", 32'h0, reverseRun);
		wr(8'h00, 32'hA);
		forward_start <= 1'b1;
		wt(100);
		near("revMag", 12'd900, freqCmd, 12'd24);
		chk("revOn", 32'h1, reverseRun);
		forward_start <= 1'b0;
		wt(100);
		chk("revOff", 32'h0, reverseRun);
		wr(8'h00, 32'h1);
	endtask

	task automatic t_ovr;
		wr(8'h00, 32'h5);
		voltMainIn <= 12'd4095;
		auxIn <= 12'sd1000;
		wt(100);
		near("ovrHi", 12'd1500, freqCmd, 12'd24);
		voltMainIn <= 12'd0;
		wt(100);
		near("ovrLo", 12'd500, freqCmd, 12'd24);
		wr(8'h08, 32'h00C8_0000);
		voltMainIn <= 12'd4095;
		wt(100);
		near("ovrGain", 12'd2000, freqCmd, 12'd30);
		auxIn <= 12'sd0;
		wt(100);
		near("ovrNoMain", 12'd0, freqCmd, 12'd24);
		wr(8'h08, 32'h0096_0032);
		// Override with polarity code: signed aux main runs by its sign
		wr(8'h00, 32'hE);
		auxIn <= -12'sd1000;
		forward_start <= 1'b1;
		wt(100);
		near("ovrRev", 12'd1500, freqCmd, 12'd24);
		chk("ovrRevDir", 32'h1, reverseRun);
		forward_start <= 1'b0;
		auxIn <= 12'sd0;
		wr(8'h00, 32'h1);
	endtask

	task automatic t_multi;
		voltMainIn <= 12'd0;
		multiSpeedActive <= 1'b1;
		multiSpeedIn <= 12'd1000;
		auxIn <= 12'sd400;
		wt(100);
		near("msNoComp", 12'd1000, freqCmd, 12'd24);
		wr(8'h00, 32'h101);
		wt(100);
		near("msComp", 12'd1400, freqCmd, 12'd24);
		multiSpeedActive <= 1'b0;
		auxIn <= 12'sd0;
		wr(8'h00, 32'h1);
	endtask

	task automatic t_offs;
		voltMainIn <= 12'd2000;
		wr(8'h14, 32'h6E);
		bus(1'b0, 8'h14, 32'h0);
		chk("offsBack", 32'h6E, rdv);
		wt(100);
		near("offsPos", 12'd1591, freqCmd, 12'd24);
		wr(8'h14, 32'h5A);
		wt(100);
		near("offsNeg", 12'd2409, freqCmd, 12'd24);
		wr(8'h14, 32'h64);
	endtask

	task automatic t_filt;
		voltMainIn <= 12'd0;
		wt(100);
		wr(8'h00, 32'h0008_0001);
		voltMainIn <= 12'd2000;
		wt(20);
		near("slowCode", 12'd0, freqCmd, 12'd150);
		wr(8'h00, 32'h1);
		wt(100);
		near("fastCode", 12'd2000, freqCmd, 12'd24);
		wr(8'h0C, 32'h1388_0000);
		wr(8'h10, 32'h1388_0000);
		second_function_select <= 1'b1;
		voltMainIn <= 12'd0;
		torqueIn <= 12'sd2000;
		wt(20);
		near("spdAlt", 12'd2000, freqCmd, 12'd60);
		near("trqAlt", 12'd0, torqueCmd, 12'd60);
		second_function_select <= 1'b0;
		wt(100);
		near("spdPri", 12'd0, freqCmd, 12'd24);
		near("trqPri", 12'd2000, torqueCmd, 12'd24);
	endtask

	task automatic results;
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog well beyond the expected run of about 7600 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		error_cnt++;
		results;
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset;
		t_modes;
		t_added;
		t_ovr;
		t_multi;
		t_offs;
		t_filt;
		results;
	end
endmodule // tb_top
